/* bench/gauge_host_register_access_bench.sv */
// self-checking bench of the gauge register access engine over i2c and the single-wire link
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
   $display("Error t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module gauge_host_register_access_bench;
   import gauge_access_pkg::*;
   localparam int unsigned UPD = 200;
   localparam int unsigned STK = 64;
   logic core_clk = 1'b0;
   logic link_clk;
   logic rst, act_below, meas_valid, meas_ready, sleep, reg_wr;
   logic scl_oe_n, sda_oe_n, scl_line, sda_line;
   logic sw_line = 1'b1;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   meas_t meas;
   int err_total = 0;
   int n_checks = 0;
   int ptr = 0;
   int mem[128];
   int seed = 32'h99528B6C;
   logic [14:0] wr_q[$];

   gauge_host_register_access #(.UPDATE_CYC(UPD), .STUCK_CYC(STK)) DUT (
      .core_clk_i(core_clk), .link_clk_i(link_clk), .rst_i(rst),
      .scl_i(scl_line), .scl_o(), .scl_oe_n_o(scl_oe_n),
      .sda_i(sda_line), .sda_o(), .sda_oe_n_o(sda_oe_n),
      .hdq_i(sw_line), .hdq_o(), .hdq_oe_n_o(),
      .meas_i(meas), .meas_valid_i(meas_valid), .meas_ready_o(meas_ready),
      .activity_below_i(act_below), .sleep_o(sleep), .reg_wr_o(reg_wr),
      .reg_wr_addr_o(wr_addr), .reg_wr_data_o(wr_data));
   i2c_host_model host (.scl_oe_n_i(scl_oe_n), .sda_oe_n_i(sda_oe_n),
      .scl_line_o(scl_line), .sda_line_o(sda_line));

   always #25 core_clk = ~core_clk;
   // odd offset keeps the link clock out of phase with the core
   initial begin
      link_clk = 1'b0;
      #11;
      forever #32 link_clk = ~link_clk;
   end
   always @(posedge core_clk) begin
      if (reg_wr) wr_q.push_back({wr_addr, wr_data});
   end

   task automatic conclude();
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // register byte then n data bytes; only the first to a writable place lands
   task automatic wrn(input logic [7:0] r, input int n);
      logic [7:0] rx, d;
      logic a, ok;
      logic [14:0] exp_q[$];
      host.start();
      host.xfer(8'hAA, 1'b1, rx, a);
      `CHK(a, 1'b0)
      host.xfer(r, 1'b1, rx, a);
      `CHK(a, r[7])
      if (!r[7]) ptr = r[6:0];
      for (int i = 0; i < n && !r[7]; i++) begin
         d = 8'($random(seed));
         ok = i == 0 && (r[6:0] == 7'h00 || r[6:0] > 7'h6D);
         host.xfer(d, 1'b1, rx, a);
         `CHK(a, !ok)
         if (ok) begin
            mem[r[6:0]] = d;
            exp_q.push_back({r[6:0], d});
            ptr = (ptr + 1) % 128;
         end
      end
      host.stop();
      repeat (20) @(posedge core_clk);
      `CHK(wr_q.size(), exp_q.size())
      foreach (exp_q[i]) `CHK(wr_q[i], exp_q[i])
      wr_q.delete();
   endtask

   // single-wire frames, lsb first: short low is a one, long low a zero
   task automatic sw_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         sw_line <= 1'b0;
         repeat (b[i] ? 200 : 1200) @(posedge core_clk);
         sw_line <= 1'b1;
         repeat (200) @(posedge core_clk);
      end
   endtask

   // full read with register byte, or quick read from the pointer
   task automatic rd(input logic quick, input logic [7:0] r, input int n);
      logic [7:0] rx;
      logic a;
      host.start();
      if (!quick) begin
         host.xfer(8'hAA, 1'b1, rx, a);
         host.xfer(r, 1'b1, rx, a);
         `CHK(a, r[7])
         if (r[7]) begin
            host.stop();
            return;
         end
         ptr = r[6:0];
         host.start();
      end
      host.xfer(8'hAB, 1'b1, rx, a);
      `CHK(a, 1'b0)
      for (int i = 0; i < n; i++) begin
         host.xfer(8'hFF, i == n - 1, rx, a);
         `CHK(rx, mem[ptr][7:0])
         if (i < n - 1) ptr = (ptr + 1) % 128;
      end
      host.stop();
   endtask

   initial begin
      repeat (80000) @(posedge core_clk);
      err_total++;
      conclude();
   end

   initial begin
      logic [7:0] rx;
      logic a;
      int ga;
      realtime t0;
      rst = 1'b1;
      act_below = 1'b0;
      meas_valid = 1'b0;
      meas = '0;
      t0 = 0;
      ga = 1;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      repeat (10) @(posedge core_clk);
      // gauge words, one per window, into read-only places
      for (int i = 0; i < 6; i++) begin
         ga = 1 + {$random(seed)} % 109;
         meas <= {1'b1, ga[6:0], 8'($random(seed))};
         meas_valid <= 1'b1;
         @(negedge core_clk);
         while (meas_ready !== 1'b1) @(negedge core_clk);
         @(posedge core_clk);
         mem[ga] = meas.data;
         if (i > 0) `CHK($realtime - t0 >= UPD * 50, 1'b1)
         t0 = $realtime;
      end
      meas_valid <= 1'b0;
      $display("test gauge updates done");
      wrn(8'h00, 1);
      wrn(8'h7F, 1);
      wrn(8'h10, 1);
      wrn(8'h6E, 3);
      wrn(8'h90, 1);
      $display("test writes done");
      sw_line <= 1'b0;
      repeat (4000) @(posedge core_clk);
      sw_line <= 1'b1;
      repeat (200) @(posedge core_clk);
      rx = 8'($random(seed));
      sw_byte(8'hF0);
      sw_byte(rx);
      repeat (20) @(posedge core_clk);
      `CHK(wr_q.size(), 1)
      `CHK(wr_q[0], {7'h70, rx})
      wr_q.delete();
      mem[7'h70] = rx;
      $display("test single-wire write done");
      host.start();
      host.xfer(8'hA8, 1'b1, rx, a);
      `CHK(a, 1'b1)
      host.stop();
      rd(1'b0, 8'h70, 1);
      rd(1'b0, {1'b0, ga[6:0]}, 2);
      rd(1'b1, 8'h00, 1);
      rd(1'b0, 8'h7E, 4);
      rd(1'b1, 8'h00, 2);
      rd(1'b0, 8'h85, 1);
      $display("test reads done");
      @(posedge core_clk);
      act_below <= 1'b1;
      fork
         host.hold_low(12000);
         begin
            #9010;
            `CHK({scl_oe_n, sda_oe_n}, 2'h3)
            `CHK(sleep, 1'b1)
         end
      join
      repeat (40) @(posedge core_clk);
      @(negedge core_clk);
      `CHK(sleep, 1'b0)
      $display("test stuck bus done");
      conclude();
   end
endmodule

/* bench/i2c_host_model.sv */
// behavioural i2c bus master facing the gauge target pins
`timescale 1ns/100ps
module i2c_host_model #(
   parameter int QTR_NS = 400
) (
   // target pin enables
   input wire logic scl_oe_n_i,
   input wire logic sda_oe_n_i,
   // resolved bus levels
   output logic scl_line_o,
   output logic sda_line_o
);
   logic scl_m;
   logic sda_m;
   // pull-ups: a released line reads high, never the last value
   assign scl_line_o = scl_m & scl_oe_n_i;
   assign sda_line_o = sda_m & sda_oe_n_i;
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   task automatic bit_io(input logic b, output logic r);
      sda_m = b;
      #QTR_NS scl_m = 1'b1;
      // target may stretch the low phase while fetching read data
      wait (scl_line_o === 1'b1);
      #QTR_NS r = sda_line_o;
      #QTR_NS scl_m = 1'b0;
      #QTR_NS;
   endtask
   // start and repeated start alike
   task automatic start();
      sda_m = 1'b1;
      #QTR_NS scl_m = 1'b1;
      #QTR_NS sda_m = 1'b0;
      #QTR_NS scl_m = 1'b0;
      #QTR_NS;
   endtask
   task automatic stop();
      sda_m = 1'b0;
      #QTR_NS scl_m = 1'b1;
      #QTR_NS sda_m = 1'b1;
      #QTR_NS;
   endtask
   // msb first, then the acknowledge slot
   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
         output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(mack, ack);
   endtask
   task automatic hold_low(input int ns);
      scl_m = 1'b0;
      #ns scl_m = 1'b1;
   endtask
endmodule

/* hdl/gauge_access_defines.svh */
// timing, address and field constants of the gauge host access engine
`ifndef GAUGE_ACCESS_DEFINES_SVH
`define GAUGE_ACCESS_DEFINES_SVH
`define NS_PER_US 1000
`define MS_PER_NS 1000000
`define CORE_PERIOD_NS 50
`define LINK_PERIOD_NS 64
`define UPDATE_PERIOD_MS 1280
`define BUS_STUCK_US 2000
`define HDQ_BREAK_US 190
`define HDQ_SPLIT_US 50
`define HDQ_DRIVE1_US 32
`define HDQ_DRIVE0_US 100
`define HDQ_CYCLE_US 190
`define HDQ_TURN_US 200
`define TARGET_ADDR 7'h55
`define RO_FIRST 7'h01
`define RO_LAST 7'h6D
`define BYTE_LAST 3'h7
`define CMD_WR_BIT 7
`endif

/* hdl/gauge_access_pkg.sv */
// types shared by the gauge host access engine
package gauge_access_pkg;
   typedef struct packed {
      logic wr;
      logic [6:0] addr;
      logic [7:0] data;
   } link_req_t;
   typedef struct packed {
      logic last;
      logic [6:0] addr;
      logic [7:0] data;
   } meas_t;
   typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_RX = 3'h1, ST_DEC = 3'h2, ST_ACK = 3'h3,
      ST_WAIT = 3'h4, ST_TX = 3'h5, ST_MACK = 3'h6} i2c_st_t;
   typedef enum logic [1:0] {KIND_DEV = 2'h0, KIND_REG = 2'h1, KIND_DATA = 2'h2} byte_kind_t;
   typedef enum logic [2:0] {H_IDLE = 3'h0, H_LOW = 3'h1, H_BREAK = 3'h2, H_TURN = 3'h3,
      H_TX = 3'h4} hdq_st_t;
endpackage

/* hdl/gauge_host_register_access.sv */
// register access engine: single-wire host link and i2c target on one register space
// Overview of operation
// R1 - command bit 7 set means write the next byte to the addressed register, clear means read.
// R2 - a read command makes the device send out the addressed register.
// R3 - command bits 6 to 0 are the register address.
// R4 - the host reads high, low, high again and rereads low when the highs differ.
// R5 - reportable values change at most once per 1.28 seconds.
// R6 - the i2c target answers only to address 1010101, bytes 0xAA and 0xAB.
// R7 - one-byte write, quick read, one-byte read with repeated start and incremental read work.
// R8 - a quick read returns the register at the current address pointer.
// R9 - the address pointer steps by one on every acknowledged data byte, from either side.
// R10 - a data byte written to a read-only register is refused and not stored.
// R11 - a register address byte above 0x7F is refused.
// R12 - every data byte after the first in a write is refused and not stored.
// R13 - after the bus stuck timeout the target lets go of both lines.
// R14 - a line still held low after that release sends the device to sleep when activity is low.
// R15 - single-wire bytes are eight bits, least significant first, at no more than 5 Kbit/s; the device sends one bit per 190 us, about 5.26 Kbit/s.
// R16 - the single-wire line held low for the break time resets the receive engine.
// R17 - both host links reach the same 7-bit register space.
`timescale 1ns/100ps
`include "gauge_access_defines.svh"
module gauge_host_register_access #(
   parameter int unsigned UPDATE_CYC = `UPDATE_PERIOD_MS * `MS_PER_NS / `CORE_PERIOD_NS,
   parameter int unsigned STUCK_CYC = `BUS_STUCK_US * `NS_PER_US / `LINK_PERIOD_NS
) (
   // clocks and reset
   input wire logic core_clk_i,
   input wire logic link_clk_i,
   input wire logic rst_i,
   // i2c pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // single-wire host link pin
   input wire logic hdq_i,
   output logic hdq_o,
   output logic hdq_oe_n_o,
   // gauge side
   input wire gauge_access_pkg::meas_t meas_i,
   input wire logic meas_valid_i,
   output logic meas_ready_o,
   input wire logic activity_below_i,
   output logic sleep_o,
   output logic reg_wr_o,
   output logic [6:0] reg_wr_addr_o,
   output logic [7:0] reg_wr_data_o
);
   import gauge_access_pkg::*;

   localparam int UW = $clog2(UPDATE_CYC);
   localparam int SW = $clog2(STUCK_CYC);
   localparam logic [UW-1:0] UPD_LAST = UW'(UPDATE_CYC - 1);
   localparam logic [SW-1:0] STK_LAST = SW'(STUCK_CYC - 1);
   localparam int CP = `CORE_PERIOD_NS;
   localparam logic [11:0] BRK_LAST = 12'((`HDQ_BREAK_US * `NS_PER_US + CP - 1) / CP - 1);
   localparam logic [11:0] SPL_LAST = 12'((`HDQ_SPLIT_US * `NS_PER_US + CP - 1) / CP - 1);
   localparam logic [11:0] D1_CYC = 12'((`HDQ_DRIVE1_US * `NS_PER_US + CP - 1) / CP);
   localparam logic [11:0] D0_CYC = 12'((`HDQ_DRIVE0_US * `NS_PER_US + CP - 1) / CP);
   localparam logic [11:0] CYC_LAST = 12'((`HDQ_CYCLE_US * `NS_PER_US + CP - 1) / CP - 1);
   localparam logic [11:0] TRN_LAST = 12'((`HDQ_TURN_US * `NS_PER_US + CP - 1) / CP - 1);

   // one map of read-only addresses serves both links
   function automatic logic writable(input logic [6:0] a);
      return !(a >= `RO_FIRST && a <= `RO_LAST); // R10 R17
   endfunction

   // link domain state
   logic lrst_s1, lrst_r;
   logic [1:0] ln_s1, ln_s2, ln_s3, ln_f, ln_chg;
   logic ack_s1, ack_s2;
   i2c_st_t st_r, st_nxt;
   byte_kind_t kind_r, kind_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, rx_byte_w;
   logic ack_r, ack_nxt, rw_r, rw_nxt, wdone_r, wdone_nxt, tog_r, tog_nxt;
   logic [6:0] ptr_r, ptr_nxt;
   link_req_t req_r, req_nxt;
   logic [SW-1:0] stk_r, stk_nxt;
   logic rel_r, rel_nxt, sda_drv_r, sda_drv_nxt, scl_drv_r, scl_drv_nxt;
   logic scl_rise, scl_fall, start_w, stop_w, fetch_pend, ev_ok;
   // core domain state
   logic [2:0] h_s;
   logic h_f, h_rose, h_fell;
   hdq_st_t hst_r, hst_nxt;
   logic [11:0] hcnt_r, hcnt_nxt;
   logic [2:0] hbits_r, hbits_nxt;
   logic [7:0] hsh_r, hsh_nxt, hcmd_r, hcmd_nxt, h_byte_w, hdq_rd_w;
   logic hph_r, hph_nxt, hdrv_r, hdrv_nxt, hdq_we;
   logic [7:0] mem_r [128];
   logic [7:0] rd_data_r, rd_data_nxt, mem_wd;
   logic [6:0] mem_wa;
   logic req_s1, req_s2, ack_tog_r, ack_tog_nxt, rel_s1, rel_s2;
   logic i2c_pend, i2c_srv, i2c_we, meas_acc, mem_we;
   logic [UW-1:0] upd_cnt_r, upd_cnt_nxt;
   logic win_r, win_nxt, sleep_r, sleep_nxt;

   // pins filtered: a change counts once the second and third stages agree
   assign ln_chg = ~(ln_s2 ^ ln_s3) & (ln_s3 ^ ln_f);
   assign scl_rise = ln_chg[1] & ln_s3[1];
   assign scl_fall = ln_chg[1] & ~ln_s3[1];
   assign start_w = ln_chg[0] & ~ln_s3[0] & ln_f[1];
   assign stop_w = ln_chg[0] & ln_s3[0] & ln_f[1];
   assign rx_byte_w = {sh_r[6:0], ln_f[0]};
   assign fetch_pend = ack_s2 != tog_r;
   assign ev_ok = !start_w && !stop_w && !rel_nxt;

   always_comb begin
      st_nxt = st_r;
      kind_nxt = kind_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      ack_nxt = ack_r;
      rw_nxt = rw_r;
      ptr_nxt = ptr_r;
      wdone_nxt = wdone_r;
      req_nxt = req_r;
      tog_nxt = tog_r;
      tx_nxt = tx_r;
      stk_nxt = stk_r;
      rel_nxt = rel_r;
      if (&ln_f) begin
         stk_nxt = '0;
         rel_nxt = 1'h0;
      end else if (|ln_chg) begin
         // a moving line is traffic, not a stuck bus: long zero runs must not trip it
         stk_nxt = '0;
      end else if (stk_r == STK_LAST) begin
         rel_nxt = 1'h1; // R13
      end else begin
         stk_nxt = stk_r + 1'h1;
      end
      if (rel_nxt) begin
         st_nxt = ST_IDLE; // R13
      end else if (start_w) begin
         st_nxt = ST_RX;
         kind_nxt = KIND_DEV;
         bit_nxt = '0;
         wdone_nxt = 1'h0;
      end else if (stop_w) begin
         st_nxt = ST_IDLE;
      end else begin
         case (st_r)
            ST_RX: if (scl_rise) begin
               sh_nxt = rx_byte_w;
               bit_nxt = bit_r + 1'h1;
               if (bit_r == `BYTE_LAST) begin
                  st_nxt = ST_DEC;
                  case (kind_r)
                     KIND_DEV: begin
                        ack_nxt = rx_byte_w[7:1] == `TARGET_ADDR; // R6
                        rw_nxt = rx_byte_w[0];
                        kind_nxt = KIND_REG;
                        if (ack_nxt && rx_byte_w[0]) begin
                           req_nxt = '{wr: 1'h0, addr: ptr_r, data: 8'h00}; // R8 R7
                           tog_nxt = !tog_r;
                        end
                     end
                     KIND_REG: begin
                        ack_nxt = !rx_byte_w[7]; // R11
                        ptr_nxt = rx_byte_w[6:0];
                        kind_nxt = KIND_DATA;
                     end
                     default: begin
                        ack_nxt = !wdone_r && writable(ptr_r); // R10 R12
                        if (ack_nxt) begin
                           req_nxt = '{wr: 1'h1, addr: ptr_r, data: rx_byte_w};
                           tog_nxt = !tog_r;
                           ptr_nxt = ptr_r + 7'h01; // R9
                           wdone_nxt = 1'h1;
                        end
                     end
                  endcase
               end
            end
            ST_DEC: if (scl_fall) begin
               st_nxt = ST_ACK;
            end
            ST_ACK: if (scl_fall) begin
               bit_nxt = '0;
               st_nxt = !ack_r ? ST_IDLE : (rw_r ? ST_WAIT : ST_RX); // R7
            end
            // scl held low until the fetched byte is back from the core side
            ST_WAIT: if (!fetch_pend && !ln_f[1]) begin
               tx_nxt = rd_data_r;
               bit_nxt = '0;
               st_nxt = ST_TX;
            end
            ST_TX: if (scl_fall) begin
               tx_nxt = {tx_r[6:0], 1'h0};
               bit_nxt = bit_r + 1'h1;
               if (bit_r == `BYTE_LAST) begin
                  st_nxt = ST_MACK;
               end
            end
            ST_MACK: if (scl_rise) begin
               ack_nxt = !ln_f[0];
               if (!ln_f[0]) begin
                  ptr_nxt = ptr_r + 7'h01; // R9
                  req_nxt = '{wr: 1'h0, addr: ptr_r + 7'h01, data: 8'h00};
                  tog_nxt = !tog_r;
               end
            end else if (scl_fall) begin
               st_nxt = ack_r ? ST_WAIT : ST_IDLE; // R7
            end
            default: st_nxt = ST_IDLE;
         endcase
      end
      sda_drv_nxt = !rel_nxt && ((st_nxt == ST_ACK && ack_nxt) || (st_nxt == ST_TX && !tx_nxt[7]));
      scl_drv_nxt = !rel_nxt && st_nxt == ST_WAIT;
   end

   always_ff @(posedge link_clk_i) begin
      lrst_s1 <= rst_i;
      lrst_r <= lrst_s1;
      ln_s1 <= {scl_i, sda_i};
      ln_s2 <= ln_s1;
      ln_s3 <= ln_s2;
      ack_s1 <= ack_tog_r;
      ack_s2 <= ack_s1;
      if (lrst_r) begin
         ln_f <= 2'h3;
         st_r <= ST_IDLE;
         kind_r <= KIND_DEV;
         bit_r <= '0;
         sh_r <= '0;
         tx_r <= '0;
         ack_r <= 1'h0;
         rw_r <= 1'h0;
         ptr_r <= '0;
         wdone_r <= 1'h0;
         req_r <= '0;
         tog_r <= 1'h0;
         stk_r <= '0;
         rel_r <= 1'h0;
         sda_drv_r <= 1'h0;
         scl_drv_r <= 1'h0;
      end else begin
         ln_f <= ln_f ^ ln_chg;
         st_r <= st_nxt;
         kind_r <= kind_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         tx_r <= tx_nxt;
         ack_r <= ack_nxt;
         rw_r <= rw_nxt;
         ptr_r <= ptr_nxt;
         wdone_r <= wdone_nxt;
         req_r <= req_nxt;
         tog_r <= tog_nxt;
         stk_r <= stk_nxt;
         rel_r <= rel_nxt;
         sda_drv_r <= sda_drv_nxt;
         scl_drv_r <= scl_drv_nxt;
      end
   end

   assign sda_o = 1'h0;
   assign scl_o = 1'h0;
   assign sda_oe_n_o = !sda_drv_r;
   assign scl_oe_n_o = !scl_drv_r;

   sequence byte_end_s;
      st_r == ST_RX && scl_rise && bit_r == `BYTE_LAST && ev_ok;
   endsequence
   dev_match_a: assert property (@(posedge link_clk_i) disable iff (lrst_r) // R6
      byte_end_s ##0 (kind_r == KIND_DEV) |=> ack_r == (sh_r[7:1] == `TARGET_ADDR))
      else $error("target address answer wrong");
   quick_read_a: assert property (@(posedge link_clk_i) disable iff (lrst_r) // R8
      byte_end_s ##0 (kind_r == KIND_DEV && rx_byte_w == {`TARGET_ADDR, 1'h1})
      |=> !req_r.wr && req_r.addr == $past(ptr_r) && tog_r != $past(tog_r))
      else $error("quick read not fetched at pointer");
   reg_range_a: assert property (@(posedge link_clk_i) disable iff (lrst_r) // R11
      byte_end_s ##0 (kind_r == KIND_REG && rx_byte_w[7]) |=> !ack_r ##1 !sda_drv_r)
      else $error("high register address not refused");
   ro_write_a: assert property (@(posedge link_clk_i) disable iff (lrst_r) // R10
      byte_end_s ##0 (kind_r == KIND_DATA && !writable(ptr_r)) |=> !ack_r && $stable(tog_r))
      else $error("read-only write not refused");
   multi_write_a: assert property (@(posedge link_clk_i) disable iff (lrst_r) // R12
      byte_end_s ##0 (kind_r == KIND_DATA && wdone_r) |=> !ack_r && $stable(req_r))
      else $error("extra write byte taken");
   ptr_step_a: assert property (@(posedge link_clk_i) disable iff (lrst_r) // R9
      st_r == ST_MACK && scl_rise && !ln_f[0] && ev_ok |=> ptr_r == $past(ptr_r) + 7'h01)
      else $error("pointer did not step on master ack");
   stuck_free_a: assert property (@(posedge link_clk_i) disable iff (lrst_r) // R13
      stk_r == STK_LAST && !(&ln_f) && !(|ln_chg) |=> rel_r && sda_oe_n_o && scl_oe_n_o)
      else $error("stuck bus not released");

   // single-wire link, sampled on the core clock
   assign h_f = h_s[2];
   assign h_rose = (h_s[1] == h_s[2]) && h_s[2] && !hdrv_r;
   assign h_fell = (h_s[1] == h_s[2]) && !h_s[2] && !hdrv_r;
   assign h_byte_w = {hcnt_r < SPL_LAST, hsh_r[7:1]}; // R15
   assign hdq_rd_w = mem_r[h_byte_w[6:0]];

   always_comb begin
      hst_nxt = hst_r;
      hcnt_nxt = hcnt_r;
      hbits_nxt = hbits_r;
      hsh_nxt = hsh_r;
      hcmd_nxt = hcmd_r;
      hph_nxt = hph_r;
      hdq_we = 1'h0;
      case (hst_r)
         H_IDLE: if (h_fell) begin
            hcnt_nxt = '0;
            hst_nxt = H_LOW;
         end
         H_LOW: begin
            hcnt_nxt = hcnt_r + 12'h001;
            if (hcnt_r == BRK_LAST) begin
               hst_nxt = H_BREAK; // R16
               hbits_nxt = '0;
               hph_nxt = 1'h0;
            end else if (h_rose) begin
               hst_nxt = H_IDLE;
               hsh_nxt = h_byte_w;
               hbits_nxt = hbits_r + 3'h1;
               if (hbits_r == `BYTE_LAST && !hph_r) begin
                  hcmd_nxt = h_byte_w;
                  hph_nxt = h_byte_w[`CMD_WR_BIT]; // R1
                  if (!h_byte_w[`CMD_WR_BIT]) begin
                     hsh_nxt = hdq_rd_w; // R2 R3
                     hcnt_nxt = '0;
                     hst_nxt = H_TURN;
                  end
               end else if (hbits_r == `BYTE_LAST) begin
                  hph_nxt = 1'h0;
                  hdq_we = writable(hcmd_r[6:0]); // R1 R17
               end
            end
         end
         H_BREAK: if (h_rose) begin
            hst_nxt = H_IDLE;
         end
         H_TURN: begin
            hcnt_nxt = hcnt_r + 12'h001;
            if (hcnt_r == TRN_LAST) begin
               hcnt_nxt = '0;
               hbits_nxt = '0;
               hst_nxt = H_TX;
            end
         end
         H_TX: begin
            hcnt_nxt = hcnt_r + 12'h001;
            if (hcnt_r == CYC_LAST) begin
               hcnt_nxt = '0;
               hsh_nxt = {1'h0, hsh_r[7:1]}; // R15
               hbits_nxt = hbits_r + 3'h1;
               if (hbits_r == `BYTE_LAST) begin
                  hst_nxt = H_IDLE;
               end
            end
         end
         default: hst_nxt = H_IDLE;
      endcase
      hdrv_nxt = hst_nxt == H_TX && (hcnt_nxt < D1_CYC || (hcnt_nxt < D0_CYC && !hsh_nxt[0]));
   end

   // one write port; host writes win, the gauge waits in its window
   assign i2c_pend = req_s2 != ack_tog_r;
   assign i2c_srv = i2c_pend && !hdq_we;
   assign i2c_we = i2c_srv && req_r.wr;
   assign meas_ready_o = win_r && !hdq_we && !(i2c_pend && req_r.wr); // R5
   assign meas_acc = meas_valid_i && meas_ready_o;
   assign mem_we = hdq_we || i2c_we || meas_acc;
   assign mem_wa = hdq_we ? hcmd_r[6:0] : (i2c_we ? req_r.addr : meas_i.addr); // R17
   assign mem_wd = hdq_we ? h_byte_w : (i2c_we ? req_r.data : meas_i.data);

   always_comb begin
      rd_data_nxt = i2c_srv ? mem_r[req_r.addr] : rd_data_r;
      ack_tog_nxt = ack_tog_r ^ i2c_srv;
      upd_cnt_nxt = (upd_cnt_r == UPD_LAST) ? '0 : upd_cnt_r + 1'h1;
      win_nxt = win_r;
      if (upd_cnt_r == UPD_LAST) begin
         win_nxt = 1'h1; // R5
      end else if (meas_acc && meas_i.last) begin
         win_nxt = 1'h0;
      end
      sleep_nxt = rel_s2 && activity_below_i; // R14
   end

   always_ff @(posedge core_clk_i) begin
      h_s <= {h_s[1:0], hdq_i};
      req_s1 <= tog_r;
      req_s2 <= req_s1;
      rel_s1 <= rel_r;
      rel_s2 <= rel_s1;
      if (rst_i) begin
         for (int i = 0; i < 128; i++) begin
            mem_r[i] <= 8'h00;
         end
         hst_r <= H_IDLE;
         hcnt_r <= '0;
         hbits_r <= '0;
         hsh_r <= '0;
         hcmd_r <= '0;
         hph_r <= 1'h0;
         hdrv_r <= 1'h0;
         rd_data_r <= '0;
         ack_tog_r <= 1'h0;
         upd_cnt_r <= '0;
         win_r <= 1'h0;
         sleep_r <= 1'h0;
         reg_wr_o <= 1'h0;
         reg_wr_addr_o <= '0;
         reg_wr_data_o <= '0;
      end else begin
         if (mem_we) begin
            mem_r[mem_wa] <= mem_wd;
         end
         hst_r <= hst_nxt;
         hcnt_r <= hcnt_nxt;
         hbits_r <= hbits_nxt;
         hsh_r <= hsh_nxt;
         hcmd_r <= hcmd_nxt;
         hph_r <= hph_nxt;
         hdrv_r <= hdrv_nxt;
         rd_data_r <= rd_data_nxt;
         ack_tog_r <= ack_tog_nxt;
         upd_cnt_r <= upd_cnt_nxt;
         win_r <= win_nxt;
         sleep_r <= sleep_nxt;
         reg_wr_o <= hdq_we || i2c_we;
         reg_wr_addr_o <= mem_wa;
         reg_wr_data_o <= mem_wd;
      end
   end

   assign hdq_o = 1'h0;
   assign hdq_oe_n_o = !hdrv_r;
   assign sleep_o = sleep_r;

   sequence hdq_cmd_rd_s;
      hst_r == H_LOW && hcnt_r != BRK_LAST && h_rose && hbits_r == `BYTE_LAST && !hph_r;
   endsequence
   hdq_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R2
      hdq_cmd_rd_s ##0 !h_byte_w[7] |=> hst_r == H_TURN && hsh_r == $past(hdq_rd_w))
      else $error("read command did not load addressed register");
   hdq_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R1
      hdq_we |=> reg_wr_o && reg_wr_data_o == $past(h_byte_w) && !hph_r)
      else $error("write command data not stored");
   hdq_break_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R16
      hst_r == H_LOW && hcnt_r == BRK_LAST |=> hst_r == H_BREAK && hbits_r == 3'h0 && !hph_r)
      else $error("break did not reset receiver");
   update_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R5
      $rose(win_r) |-> $past(upd_cnt_r) == UPD_LAST)
      else $error("update window opened early");
   sleep_entry_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // R14
      rel_s2 && activity_below_i |=> sleep_o)
      else $error("sleep not entered");
endmodule
